// ---- src/sfgc_map.svh ----
// register offsets, field positions, reset values and timing counts of the forwarding control bank
// assumes an 8-bit register address space and 8-bit register data
`ifndef SFGC_MAP_SVH
`define SFGC_MAP_SVH

`define SFGC_ADDR_UVID 8'h85
`define SFGC_ADDR_SELF 8'h86
`define SFGC_ADDR_RATE 8'h87

`define SFGC_FWD_EN_BIT 5
`define SFGC_SELF_EN_BIT 6
`define SFGC_QUEUE_EGR_BIT 3
`define SFGC_SRC_PVID_BIT 2
`define SFGC_PERIOD_LSB 4

`define SFGC_MAP_RST 5'h00
`define SFGC_PERIOD_RST 2'h1
`define SFGC_UVID_RD_MASK 8'h3F
`define SFGC_SELF_RD_MASK 8'h7F
`define SFGC_RATE_RD_MASK 8'h3C

`define SFGC_CLK_MHZ 125
`define SFGC_PERIOD16_MS 16
`define SFGC_PERIOD64_MS 64
`define SFGC_PERIOD256_MS 256
`define SFGC_MS_CYCLES (`SFGC_CLK_MHZ * 1000)

`endif

// ---- src/sfgc_pkg.sv ----
// types shared by the forwarding control bank and its helpers
// assumes a switch with ports 1 and 2 plus the rest reached by flooding
package sfgc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfgc_bus_req_type;

   typedef struct packed {
      logic flood;
      logic port2;
      logic port1;
      logic filter;
   } sfgc_fwd_dest_type;

   typedef struct packed {
      logic is_unknown_vid;
      logic is_unknown_ip_mcast;
      logic da_is_self;
      logic src_pvid_insert;
      logic ingress_pvid_insert;
   } sfgc_frame_info_type;

   typedef enum logic [1:0] {
      SFGC_EGR_PORT,
      SFGC_EGR_QUEUE
   } sfgc_egr_mode_type;

endpackage

// ---- src/sfgc_map_decode.sv ----
// decodes a 5-bit forwarding port map and its enable into a destination set
// assumes the map comes straight from a control register
`timescale 1ns/1ps
`include "sfgc_map.svh"

module sfgc_map_decode
   import sfgc_pkg::*;
(
   // configuration
   input wire logic enable,
   input wire logic [4:0] port_map,
   // result
   output sfgc_pkg::sfgc_fwd_dest_type dest
);
   import sfgc_pkg::*;

   // bit 0 never takes part; 00001 is reserved and treated as filtering
   always_comb begin
      dest = '0;
      if (!enable || port_map[4:1] == 4'h0) begin
         dest.filter = 1'b1;
      end else if (port_map[4:1] == 4'hF) begin
         dest.flood = 1'b1;
      end else begin
         dest.port1 = port_map[1];
         dest.port2 = port_map[2];
         dest.filter = !(port_map[1] || port_map[2]);
      end
   end

endmodule

// ---- src/sfgc_period_timer.sv ----
// ticks once per ingress rate-limit unit period
// assumes the period code may change at any time; the running count restarts on a change
`timescale 1ns/1ps
`include "sfgc_map.svh"

module sfgc_period_timer #(
   parameter int MS_CYCLES = `SFGC_MS_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // period code
   input wire logic [1:0] period_sel,
   // tick
   output logic period_tick
);
   import sfgc_pkg::*;

   // 17 bits: one millisecond at the full clock rate is more than 65535 cycles
   logic [16:0] ms_count_q;
   logic [8:0] ms_total_q;
   logic [1:0] sel_q;
   logic ms_tick;
   logic [8:0] ms_limit;

   assign ms_tick = (ms_count_q == 17'(MS_CYCLES - 1));

   // both 1x codes give the longest period
   always_comb begin
      unique case (period_sel)
         2'h0: ms_limit = 9'(`SFGC_PERIOD16_MS);
         2'h1: ms_limit = 9'(`SFGC_PERIOD64_MS);
         2'h2: ms_limit = 9'(`SFGC_PERIOD256_MS);
         2'h3: ms_limit = 9'(`SFGC_PERIOD256_MS);
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_q <= `SFGC_PERIOD_RST;
      end else begin
         sel_q <= period_sel;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ms_count_q <= 17'h00000;
      end else if (ms_tick || sel_q != period_sel) begin
         ms_count_q <= 17'h00000;
      end else begin
         ms_count_q <= ms_count_q + 17'h00001;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ms_total_q <= 9'h000;
         period_tick <= 1'b0;
      end else if (sel_q != period_sel) begin
         ms_total_q <= 9'h000;
         period_tick <= 1'b0;
      end else if (ms_tick && ms_total_q == ms_limit - 9'h001) begin
         ms_total_q <= 9'h000;
         period_tick <= 1'b1;
      end else begin
         if (ms_tick) begin
            ms_total_q <= ms_total_q + 9'h001;
         end
         period_tick <= 1'b0;
      end
   end

endmodule

// ---- src/sfgc_regs.sv ----
// global forwarding and policing control bank of a managed switch
// assumes a single-cycle register port from the management interface and
// per-frame classification inputs from the lookup engine, valid while frame_valid is high
`timescale 1ns/1ps
`include "sfgc_map.svh"

module sfgc_regs
   import sfgc_pkg::*;
#(
   parameter int MS_CYCLES = `SFGC_MS_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input sfgc_pkg::sfgc_bus_req_type bus_req,
   output logic [7:0] rd_data,
   // frame classification from the lookup path
   input wire logic frame_valid,
   input sfgc_pkg::sfgc_frame_info_type frame_info,
   // forwarding decision
   output sfgc_pkg::sfgc_fwd_dest_type fwd_dest,
   output logic egress_drop,
   output logic insert_pvid,
   // policing controls
   output sfgc_pkg::sfgc_egr_mode_type egr_mode,
   output logic rate_period_tick
);
   import sfgc_pkg::*;

   logic uvid_en_q;
   logic [4:0] uvid_map_q;
   logic self_en_q;
   logic ipm_en_q;
   logic [4:0] ipm_map_q;
   logic [1:0] period_q;
   logic queue_egr_q;
   logic src_pvid_q;
   logic [7:0] rd_data_d;
   sfgc_fwd_dest_type uvid_dest;
   sfgc_fwd_dest_type ipm_dest;
   sfgc_fwd_dest_type fwd_dest_d;

   function automatic logic is_write(input sfgc_bus_req_type r, input logic [7:0] a);
      return r.wr && r.addr == a;
   endfunction

   // only the documented bits are stored; reserved bits are never kept
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         uvid_en_q <= 1'b0;
         uvid_map_q <= `SFGC_MAP_RST;
      end else if (is_write(bus_req, `SFGC_ADDR_UVID)) begin
         uvid_en_q <= bus_req.wdata[`SFGC_FWD_EN_BIT];
         uvid_map_q <= bus_req.wdata[4:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         self_en_q <= 1'b0;
         ipm_en_q <= 1'b0;
         ipm_map_q <= `SFGC_MAP_RST;
      end else if (is_write(bus_req, `SFGC_ADDR_SELF)) begin
         self_en_q <= bus_req.wdata[`SFGC_SELF_EN_BIT];
         ipm_en_q <= bus_req.wdata[`SFGC_FWD_EN_BIT];
         ipm_map_q <= bus_req.wdata[4:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         period_q <= `SFGC_PERIOD_RST;
         queue_egr_q <= 1'b0;
         src_pvid_q <= 1'b0;
      end else if (is_write(bus_req, `SFGC_ADDR_RATE)) begin
         period_q <= bus_req.wdata[`SFGC_PERIOD_LSB +: 2];
         queue_egr_q <= bus_req.wdata[`SFGC_QUEUE_EGR_BIT];
         src_pvid_q <= bus_req.wdata[`SFGC_SRC_PVID_BIT];
      end
   end

   // reserved fields read their zero defaults; unmapped addresses read zero
   always_comb begin
      rd_data_d = 8'h00;
      unique case (bus_req.addr)
         `SFGC_ADDR_UVID: rd_data_d = {2'h0, uvid_en_q, uvid_map_q} & `SFGC_UVID_RD_MASK;
         `SFGC_ADDR_SELF: rd_data_d = {1'b0, self_en_q, ipm_en_q, ipm_map_q} & `SFGC_SELF_RD_MASK;
         `SFGC_ADDR_RATE: rd_data_d = {2'h0, period_q, queue_egr_q, src_pvid_q, 2'h0} & `SFGC_RATE_RD_MASK;
         default: rd_data_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (bus_req.rd) begin
         rd_data <= rd_data_d;
      end else begin
         rd_data <= 8'h00;
      end
   end

   sfgc_map_decode u_uvid_decode (
      .enable(uvid_en_q),
      .port_map(uvid_map_q),
      .dest(uvid_dest)
   );

   sfgc_map_decode u_ipm_decode (
      .enable(ipm_en_q),
      .port_map(ipm_map_q),
      .dest(ipm_dest)
   );

   // unknown VID takes precedence; a frame that is neither gets no unknown-class forwarding
   always_comb begin
      fwd_dest_d = '0;
      if (frame_info.is_unknown_vid) begin
         fwd_dest_d = uvid_dest;
      end else if (frame_info.is_unknown_ip_mcast) begin
         fwd_dest_d = ipm_dest;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fwd_dest <= '0;
      end else if (frame_valid) begin
         fwd_dest <= fwd_dest_d;
      end
   end

   // da_is_self comes from the egress compare against the six MAC address registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         egress_drop <= 1'b0;
      end else if (frame_valid) begin
         egress_drop <= self_en_q && frame_info.da_is_self;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         insert_pvid <= 1'b0;
      end else if (frame_valid) begin
         if (src_pvid_q) begin
            insert_pvid <= frame_info.src_pvid_insert;
         end else begin
            insert_pvid <= frame_info.ingress_pvid_insert;
         end
      end
   end

   assign egr_mode = queue_egr_q ? SFGC_EGR_QUEUE : SFGC_EGR_PORT;

   sfgc_period_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_period (
      .clock(clock),
      .rst(rst),
      .period_sel(period_q),
      .period_tick(rate_period_tick)
   );

   a_uvid_write_back: assert property (@(posedge clock) disable iff (rst)
      bus_req.wr && bus_req.addr == `SFGC_ADDR_UVID ##1 bus_req.rd && bus_req.addr == `SFGC_ADDR_UVID
      |=> rd_data == ($past(bus_req.wdata, 2) & `SFGC_UVID_RD_MASK))
      else $error("unknown VID register readback wrong");

   a_map_zero_filter: assert property (@(posedge clock) disable iff (rst)
      frame_valid && frame_info.is_unknown_vid && uvid_map_q[4:1] == 4'h0 |=> fwd_dest.filter)
      else $error("zero VID map did not filter");

   a_map_both_ports: assert property (@(posedge clock) disable iff (rst)
      frame_valid && frame_info.is_unknown_vid && uvid_en_q && uvid_map_q[4:1] == 4'h3
      |=> fwd_dest.port1 && fwd_dest.port2 && !fwd_dest.flood)
      else $error("0011x map did not send to ports 1 and 2");

   a_self_drop: assert property (@(posedge clock) disable iff (rst)
      frame_valid |=> egress_drop == ($past(self_en_q) && $past(frame_info.da_is_self)))
      else $error("self address drop wrong");

   a_ipm_flood: assert property (@(posedge clock) disable iff (rst)
      frame_valid && !frame_info.is_unknown_vid && frame_info.is_unknown_ip_mcast
      && ipm_en_q && ipm_map_q[4:1] == 4'hF |=> fwd_dest.flood && !fwd_dest.filter)
      else $error("IP multicast flood map not honoured");

   a_ipm_disabled: assert property (@(posedge clock) disable iff (rst)
      frame_valid && !frame_info.is_unknown_vid && frame_info.is_unknown_ip_mcast && !ipm_en_q
      |=> fwd_dest.filter)
      else $error("disabled IP multicast forward not filtered");

   a_egr_mode_follow: assert property (@(posedge clock) disable iff (rst)
      bus_req.wr && bus_req.addr == `SFGC_ADDR_RATE
      |=> egr_mode == ($past(bus_req.wdata[`SFGC_QUEUE_EGR_BIT]) ? SFGC_EGR_QUEUE : SFGC_EGR_PORT))
      else $error("egress limit mode did not follow write");

   a_pvid_select: assert property (@(posedge clock) disable iff (rst)
      frame_valid && !src_pvid_q |=> insert_pvid == $past(frame_info.ingress_pvid_insert))
      else $error("global PVID insertion not used");

   a_pvid_source: assert property (@(posedge clock) disable iff (rst)
      frame_valid && src_pvid_q |=> insert_pvid == $past(frame_info.src_pvid_insert))
      else $error("source port PVID insertion not used");

   a_rsvd_read_zero: assert property (@(posedge clock) disable iff (rst)
      bus_req.rd && bus_req.addr == `SFGC_ADDR_RATE |=> rd_data[7:6] == 2'h0 && rd_data[1:0] == 2'h0)
      else $error("reserved bits not zero");

   a_period_tick_pulse: assert property (@(posedge clock) disable iff (rst)
      rate_period_tick |=> !rate_period_tick)
      else $error("period tick longer than one cycle");

   a_map_port_two: assert property (@(posedge clock) disable iff (rst)
      frame_valid && frame_info.is_unknown_vid && uvid_en_q && uvid_map_q[4:1] == 4'h2
      |=> fwd_dest.port2 && !fwd_dest.port1 && !fwd_dest.filter)
      else $error("0010x map did not send to port 2 only");

   a_uvid_disabled: assert property (@(posedge clock) disable iff (rst)
      frame_valid && frame_info.is_unknown_vid && !uvid_en_q |=> fwd_dest.filter && !fwd_dest.flood)
      else $error("disabled unknown VID forward not filtered");

   a_fwd_hold: assert property (@(posedge clock) disable iff (rst)
      !frame_valid |=> $stable(fwd_dest) && $stable(egress_drop) && $stable(insert_pvid))
      else $error("frame decision changed without a frame");

   a_rd_idle_zero: assert property (@(posedge clock) disable iff (rst)
      !bus_req.rd |=> rd_data == 8'h00)
      else $error("read data not zero outside read cycle");

   a_self_write_back: assert property (@(posedge clock) disable iff (rst)
      bus_req.wr && bus_req.addr == `SFGC_ADDR_SELF ##1 bus_req.rd && bus_req.addr == `SFGC_ADDR_SELF
      |=> rd_data == ($past(bus_req.wdata, 2) & `SFGC_SELF_RD_MASK))
      else $error("self filter register readback wrong");

   a_rate_write_back: assert property (@(posedge clock) disable iff (rst)
      bus_req.wr && bus_req.addr == `SFGC_ADDR_RATE ##1 bus_req.rd && bus_req.addr == `SFGC_ADDR_RATE
      |=> rd_data == ($past(bus_req.wdata, 2) & `SFGC_RATE_RD_MASK))
      else $error("rate limit register readback wrong");

   c_uvid_forward: cover property (@(posedge clock) disable iff (rst)
      frame_valid && frame_info.is_unknown_vid && uvid_en_q ##1 fwd_dest.port1);
   c_self_drop: cover property (@(posedge clock) disable iff (rst) egress_drop);
   c_period_tick: cover property (@(posedge clock) disable iff (rst) rate_period_tick);
   c_queue_mode: cover property (@(posedge clock) disable iff (rst) egr_mode == SFGC_EGR_QUEUE);

endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the forwarding control bank: register port, frame decisions, period tick
// assumes the bank is the only thing on the register port and the frame inputs
`timescale 1ns/1ps
`include "sfgc_map.svh"

module tb_top;
   import sfgc_pkg::*;
   // short ms so that all four period codes fit in the run
   localparam int MS = 2;
   typedef struct packed {
      logic [7:0] r85;
      logic [7:0] r86;
      logic [7:0] r87;
      logic [4:0] info;
      logic [5:0] exp;
   } sfgc_tb_row_type;
   logic clock;
   logic rst;
   logic frame_valid;
   logic rate_period_tick;
   logic egress_drop;
   logic insert_pvid;
   logic [7:0] rd_data;
   sfgc_bus_req_type bus_req;
   sfgc_frame_info_type frame_info;
   sfgc_fwd_dest_type fwd_dest;
   sfgc_egr_mode_type egr_mode;
   int errors;
   int checks;
   int cycles;
   int n;
   sfgc_tb_row_type rows [0:18];

   sfgc_regs #(.MS_CYCLES(MS)) uut (
      .clock(clock), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
      .frame_valid(frame_valid), .frame_info(frame_info), .fwd_dest(fwd_dest),
      .egress_drop(egress_drop), .insert_pvid(insert_pvid), .egr_mode(egr_mode),
      .rate_period_tick(rate_period_tick));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task report_and_stop;
      if (errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         report_and_stop;
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask

   // read data is only valid in the cycle after the strobe
   task bus_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 chk({8'h00, rd_data}, {8'h00, e});
   endtask

   task frame(input logic [4:0] fi);
      @(posedge clock);
      frame_valid <= 1'b1;
      frame_info <= fi;
      @(posedge clock);
      frame_valid <= 1'b0;
      #1;
   endtask

   task tick_gap(input logic [1:0] code, input int exp);
      bus_wr(`SFGC_ADDR_RATE, {2'b00, code, 4'h0});
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clock);
            #1 n = n + 1;
         end while (rate_period_tick !== 1'b1 && n < 2000);
      end
      chk(16'(n), 16'(exp));
   endtask

   initial begin
      rst = 1'b1;
      bus_req = '0;
      frame_valid = 1'b0;
      frame_info = '0;
      errors = 0;
      checks = 0;
      cycles = 0;
      rows = '{'{8'hE6, 8'h00, 8'hC0, 5'h10, 6'h18}, '{8'h02, 8'h00, 8'h10, 5'h10, 6'h04},
               '{8'h23, 8'h00, 8'h10, 5'h10, 6'h08}, '{8'h25, 8'h00, 8'h10, 5'h10, 6'h10},
               '{8'h21, 8'h00, 8'h10, 5'h10, 6'h04}, '{8'h3F, 8'h00, 8'h10, 5'h10, 6'h20},
               '{8'h20, 8'h00, 8'h10, 5'h10, 6'h04}, '{8'h31, 8'h00, 8'h10, 5'h10, 6'h04},
               '{8'h3F, 8'hA6, 8'h08, 5'h08, 6'h18}, '{8'h3F, 8'h1E, 8'h08, 5'h08, 6'h04},
               '{8'h00, 8'h3F, 8'h10, 5'h08, 6'h20}, '{8'h22, 8'h24, 8'h10, 5'h18, 6'h08},
               '{8'h3F, 8'hFF, 8'h10, 5'h00, 6'h00}, '{8'h00, 8'h40, 8'h10, 5'h04, 6'h02},
               '{8'h00, 8'h00, 8'h10, 5'h04, 6'h00}, '{8'h00, 8'h00, 8'h04, 5'h02, 6'h01},
               '{8'h00, 8'h00, 8'h07, 5'h01, 6'h00}, '{8'h00, 8'h00, 8'h00, 5'h01, 6'h01},
               '{8'h00, 8'h00, 8'h00, 5'h02, 6'h00}};
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      #1 chk({8'h00, egr_mode, fwd_dest, egress_drop, insert_pvid}, 16'h0000);
      bus_rd(`SFGC_ADDR_UVID, 8'h00);
      bus_rd(`SFGC_ADDR_SELF, 8'h00);
      bus_rd(`SFGC_ADDR_RATE, 8'h10);
      bus_wr(8'h88, 8'hFF);
      bus_rd(8'h88, 8'h00);
      bus_rd(8'h84, 8'h00);
      for (int i = 0; i < 19; i++) begin
         bus_wr(`SFGC_ADDR_UVID, rows[i].r85);
         bus_wr(`SFGC_ADDR_SELF, rows[i].r86);
         bus_wr(`SFGC_ADDR_RATE, rows[i].r87);
         bus_rd(`SFGC_ADDR_UVID, rows[i].r85 & `SFGC_UVID_RD_MASK);
         bus_rd(`SFGC_ADDR_SELF, rows[i].r86 & `SFGC_SELF_RD_MASK);
         bus_rd(`SFGC_ADDR_RATE, rows[i].r87 & `SFGC_RATE_RD_MASK);
         frame(rows[i].info);
         chk({8'h00, egr_mode, fwd_dest, egress_drop, insert_pvid},
             {8'h00, rows[i].r87[3] ? SFGC_EGR_QUEUE : SFGC_EGR_PORT, rows[i].exp});
      end
      // write then read with no gap between strobes
      @(posedge clock);
      bus_req <= '{`SFGC_ADDR_UVID, 8'hE5, 1'b1, 1'b0};
      @(posedge clock);
      bus_req <= '{`SFGC_ADDR_UVID, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1 chk({8'h00, rd_data}, 16'h0025);
      @(posedge clock);
      #1 chk({8'h00, rd_data}, 16'h0000);
      @(posedge clock);
      bus_req <= '{`SFGC_ADDR_RATE, 8'hFF, 1'b1, 1'b0};
      @(posedge clock);
      bus_req <= '{`SFGC_ADDR_RATE, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1 chk({8'h00, rd_data}, 16'h003C);
      bus_wr(`SFGC_ADDR_RATE, 8'h10);
      // frames on consecutive cycles; the second decision must hold afterwards
      @(posedge clock);
      frame_valid <= 1'b1;
      frame_info <= 5'h10;
      @(posedge clock);
      frame_info <= 5'h0C;
      #1 chk({11'h000, fwd_dest, egress_drop}, 16'h0008);
      @(posedge clock);
      frame_valid <= 1'b0;
      #1 chk({11'h000, fwd_dest, egress_drop}, 16'h0002);
      @(posedge clock);
      #1 chk({11'h000, fwd_dest, egress_drop}, 16'h0002);
      tick_gap(2'b00, `SFGC_PERIOD16_MS * MS);
      tick_gap(2'b01, `SFGC_PERIOD64_MS * MS);
      tick_gap(2'b10, `SFGC_PERIOD256_MS * MS);
      tick_gap(2'b11, `SFGC_PERIOD256_MS * MS);
      // reset in mid-run restores the self filter and rate register defaults
      bus_wr(`SFGC_ADDR_SELF, 8'h40);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      bus_rd(`SFGC_ADDR_SELF, 8'h00);
      bus_rd(`SFGC_ADDR_RATE, 8'h10);
      report_and_stop;
   end
endmodule
